// ===== design/mxc_pkg.sv
// How it works
// - msix enabled and msi disabled: messages allowed, legacy intx pin held off
// - msix enable clear: no msix message is ever issued
// - msix enable is read/write and resets to zero
// - function mask set masks every vector; clear lets per-vector masks decide
// - writing function mask never changes per-vector mask bits
// - function mask is read/write and resets to zero
// - control bits 13 to 11 read zero and ignore writes
// - table size field reads constant one, a two-entry table
// - table locator bits 31 to 3 give read-only table offset
// - table indicator bits 2 to 0 select base register, 6 and 7 reserved
// - indicator points at the base register at configuration offset 20h
// - pending locator bits 31 to 3 give read-only pending-array offset
// - pending indicator uses the same encoding as the table indicator
// - msi enable is bit 0 of msi control; msi also turns intx off
// - each vector mask bit resets set, so vectors start masked
package mxc_pkg;
   localparam int mxc_vec_n = 2;
   localparam logic [7:0] mxc_cap_off = 8'h00;
   localparam logic [7:0] mxc_tbl_off = 8'h04;
   localparam logic [7:0] mxc_pba_off = 8'h08;
   localparam int mxc_en_bit = 15;
   localparam int mxc_fm_bit = 14;
   localparam int mxc_msi_en_bit = 0;
   localparam logic [10:0] mxc_tbl_size = 11'h001;
   localparam logic [2:0] mxc_rsvd_bits = 3'h0;
   localparam logic [2:0] mxc_bir_sel = 3'h4;
   localparam logic [28:0] mxc_tbl_qw = 29'h0000000;
   localparam logic [28:0] mxc_pba_qw = 29'h0000100;
   localparam logic [7:0] mxc_cap_id = 8'h11;
   localparam logic [7:0] mxc_next_ptr = 8'h00;
endpackage

// ===== design/mxc_regs.sv
`timescale 1ns/1ps
module mxc_regs
   import mxc_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_addr,
   input wire logic [31:0] cfg_wdata,
   input wire logic [3:0] cfg_be,
   output logic [31:0] cfg_rdata,
   input wire logic msi_enable,
   input wire logic intx_req,
   output logic intx_drive,
   input wire logic [mxc_vec_n-1:0] vec_mask_wr,
   input wire logic [mxc_vec_n-1:0] vec_mask_val,
   output logic [mxc_vec_n-1:0] vec_mask,
   input wire logic [mxc_vec_n-1:0] vec_req,
   output logic [mxc_vec_n-1:0] vec_pending,
   output logic [mxc_vec_n-1:0] msg_send,
   output logic msix_enable,
   output logic func_mask
);
   ////////////////////////////////////////////////////////////////
   logic en_r;
   logic fm_r;
   logic [mxc_vec_n-1:0] vmask_r;
   logic [mxc_vec_n-1:0] pend_r;
   logic [mxc_vec_n-1:0] send_r;
   logic [31:0] rdata_r;
   logic cap_hit;
   logic fire_ok;
   logic [31:0] rd_word;

   assign cap_hit = cfg_addr == mxc_cap_off;
   // msi wins over msix; either one keeps intx quiet
   assign fire_ok = en_r && !msi_enable && !fm_r;

   ////////////////////////////////////////////////////////////////
   // byte lane 3 holds control bits 15:8; rsvd 13:11 never stored
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         en_r <= 1'b0;
         fm_r <= 1'b0;
      end else if (cfg_wr && cap_hit && cfg_be[3]) begin
         en_r <= cfg_wdata[16 + mxc_en_bit];
         fm_r <= cfg_wdata[16 + mxc_fm_bit];
      end
   end

   // vector masks have their own write path, untouched by fm writes
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         vmask_r <= '1;
      end else begin
         for (int i = 0; i < mxc_vec_n; i++) begin
            if (vec_mask_wr[i]) begin
               vmask_r[i] <= vec_mask_val[i];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // a new request goes out at once if allowed, else is held pending; a held one goes out once allowed
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pend_r <= '0;
         send_r <= '0;
      end else begin
         for (int i = 0; i < mxc_vec_n; i++) begin
            if ((pend_r[i] || vec_req[i]) && fire_ok && !vmask_r[i]) begin
               send_r[i] <= 1'b1;
               pend_r[i] <= 1'b0;
            end else begin
               send_r[i] <= 1'b0;
               pend_r[i] <= pend_r[i] || vec_req[i];
            end
         end
      end
   end

   // intx is blocked while msi or msix is on
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         intx_drive <= 1'b0;
      end else begin
         intx_drive <= intx_req && !msi_enable && !en_r;
      end
   end

   ////////////////////////////////////////////////////////////////
   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (cfg_addr)
         mxc_cap_off: rd_word = {en_r, fm_r, mxc_rsvd_bits, mxc_tbl_size,
            mxc_next_ptr, mxc_cap_id};
         mxc_tbl_off: rd_word = {mxc_tbl_qw, mxc_bir_sel};
         mxc_pba_off: rd_word = {mxc_pba_qw, mxc_bir_sel};
         default: rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rdata_r <= 32'h0000_0000;
      end else if (cfg_rd) begin
         rdata_r <= rd_word;
      end
   end

   assign cfg_rdata = rdata_r;
   assign vec_mask = vmask_r;
   assign vec_pending = pend_r;
   assign msg_send = send_r;
   assign msix_enable = en_r;
   assign func_mask = fm_r;
endmodule

// ===== tb/mxc_regs_assertions.sv
`timescale 1ns/1ps
module mxc_chk (input wire logic core_clk, sys_rst, msi_enable, msix_enable, func_mask,
   intx_drive, input wire logic [1:0] vec_req, vec_mask, vec_mask_wr, vec_pending, msg_send);
default clocking @(posedge core_clk); endclocking
default disable iff (sys_rst);
// two cycles because intx_drive is registered one edge behind its cause
sequence s_intx_off; (msi_enable || msix_enable) [*2]; endsequence
a_intx_held_off: assert property (s_intx_off |-> !intx_drive)
   else $error("intx driven");
a_no_send_off: assert property (msg_send != 0 |-> $past(msix_enable) && !$past(msi_enable))
   else $error("send while off");
a_fm_blocks: assert property (msg_send != 0 |-> !$past(func_mask))
   else $error("send under fmask");
a_vmask_blocks: assert property ((msg_send & $past(vec_mask)) == 2'h0)
   else $error("send under vmask");
a_req_sent: assert property (vec_req[0] && msix_enable && !msi_enable && !func_mask
   && !vec_mask[0] |=> msg_send[0]) else $error("no send");
a_held_pend: assert property (vec_req[0] && (func_mask || vec_mask[0]) |=> vec_pending[0])
   else $error("not pending");
a_mask_keep: assert property (
   $changed(func_mask) && !$past(|vec_mask_wr) |-> $stable(vec_mask))
   else $error("vmask moved");
a_rst_vals: assert property (
   $fell(sys_rst) |-> !msix_enable && !func_mask && vec_mask == 2'h3)
   else $error("reset values");
endmodule
////////////////////////////////////////////////////////////////
bind mxc_regs mxc_chk u_chk(.*);

// ===== tb/mxc_host.sv
`timescale 1ns/1ps
module mxc_host (input wire logic core_clk, output logic cfg_wr, cfg_rd,
   output logic [7:0] cfg_addr, output logic [31:0] cfg_wdata, output logic [3:0] cfg_be);
initial {cfg_wr, cfg_rd, cfg_addr, cfg_wdata, cfg_be} = '0;
// configuration software alone writes the enable; one-cycle strobe per access
task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
   @(negedge core_clk) {cfg_wr, cfg_rd, cfg_addr, cfg_wdata, cfg_be} = {w, !w, a, d, 4'hf};
   @(negedge core_clk) {cfg_wr, cfg_rd} = 2'h0;
   cfg_wdata = ~cfg_wdata;
endtask
endmodule

// ===== tb/test_mxc_regs.sv
`timescale 1ns/1ps
module test_mxc_regs;
logic core_clk = 0, sys_rst = 1, msi_enable = 0, intx_req = 1, intx_drive, msix_enable, func_mask;
logic cfg_wr, cfg_rd;
logic [7:0] cfg_addr;
logic [31:0] cfg_wdata, cfg_rdata;
logic [3:0] cfg_be;
logic [1:0] vm_wr = 0, vm_val = 0, vec_req = 0, vec_mask, vec_pending, msg_send;
int num_errors = 0, n_checks = 0, cyc = 0;
always #5 core_clk = ~core_clk;
mxc_host host(.core_clk(core_clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
   .cfg_wdata(cfg_wdata), .cfg_be(cfg_be));
mxc_regs DUT(.*, .vec_mask_wr(vm_wr), .vec_mask_val(vm_val));
task chk(input string n, input logic [31:0] s, e);
   n_checks++;
   if (s !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, s);
   end
endtask
task rd(input logic [7:0] a, input logic [31:0] e);
   host.acc(0, a, 0);
   @(negedge core_clk) chk("rdata", cfg_rdata, e);
endtask
task report_and_stop;
   $display("checks %0d errors %0d", n_checks, num_errors);
   if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
   else $display("Run complete: FAIL");
   $finish;
endtask
always @(posedge core_clk) if (++cyc > 500) begin
   num_errors++;
   report_and_stop;
end
task t_regs;
   rd(8'h00, 32'h0001_0011);
   chk("intx", intx_drive, 1);
   rd(8'h04, 32'h0000_0004);
   rd(8'h08, 32'h0000_0804);
   rd(8'h0c, 0);
   chk("vmask", vec_mask, 3);
   host.acc(1, 8'h00, 32'hffff_ffff);
   host.acc(1, 8'h04, 32'hffff_ffff);
   rd(8'h00, 32'hc001_0011);
   rd(8'h04, 32'h0000_0004);
   $display("t_regs done");
endtask
task t_mask;
   @(negedge core_clk) vm_wr = 1;
   @(negedge core_clk) {vm_wr, vec_req} = 4'h1;
   @(negedge core_clk) vec_req = 0;
   chk("pend", vec_pending, 1);
   host.acc(1, 8'h00, 32'h8000_0000);
   chk("vmask", vec_mask, 2);
   @(negedge core_clk) chk("pend", vec_pending, 0);
   chk("send", msg_send, 1);
   chk("intx", intx_drive, 0);
   $display("t_mask done");
endtask
task t_off;
   @(negedge core_clk) vec_req = 1;
   @(negedge core_clk) {msi_enable, vec_req} = 3'h5;
   chk("send", msg_send, 1);
   @(negedge core_clk) vec_req = 0;
   chk("pend", vec_pending, 1);
   chk("send", msg_send, 0);
   host.acc(1, 8'h00, 0);
   msi_enable = 0;
   repeat (2) @(negedge core_clk);
   chk("pend", vec_pending, 1);
   chk("send", msg_send, 0);
   $display("t_off done");
endtask
initial begin
   repeat (10) @(negedge core_clk);
   sys_rst = 0;
   t_regs;
   t_mask;
   t_off;
   report_and_stop;
end
endmodule
